// [testbench/fdm_link_monitor.sv]
/*
 Checker for the fault manager link: flags, state and error pin.
 Assumes it sits beside the link interface and sees its signals.
*/
module fdm_link_monitor #(
   parameter int PULSE_CYC = fdm_pkg::ERR_PULSE_CYC // Error pulse length
) (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic powerOnFlagClear, // Power-on clear
   input wire logic failsafeExitClear, // Fail-safe exit
   input wire logic [fdm_pkg::FLAG_W-1:0] flags, // Flags
   input wire logic [1:0] devState, // State
   input wire logic errOe // Pin pulled low
);
   timeunit 1ns;
   timeprecision 1ns;
   import fdm_pkg::*;
   int errCnt_q;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // Length of a pull-down once running
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)
         errCnt_q <= 0;
      else if (errOe && devState[1])
         errCnt_q <= errCnt_q + 1;
      else
         errCnt_q <= 0;
   end
   chk_init_flags: assert property (devState == FDM_INIT |-> ##[0:2] (flags[0] && flags[1]))
      else $error("power-on flags missing");
   chk_por_clear: assert property (powerOnFlagClear |-> ##2 !flags[F_POR])
      else $error("power-on flag not cleared");
   chk_lowsup_err: assert property ($rose(flags[F_LOWSUP]) |-> flags[F_ERR])
      else $error("low-supply without error flag");
   chk_uv_pin: assert property ($rose(flags[F_SUPUV]) |-> ##[0:1] errOe)
      else $error("undervoltage pin not low");
   chk_crc_err: assert property ($rose(flags[F_CRC]) |-> flags[F_ERR])
      else $error("crc without error flag");
   chk_pulse_len: assert property (errOe && !flags[F_SUPUV] |-> errCnt_q <= PULSE_CYC + 2)
      else $error("error pulse too long");
   chk_fs_flag: assert property ($rose(devState == FDM_FAILSAFE) |-> ##[0:2] flags[F_FS])
      else $error("fail-safe flag missing");
   chk_fs_exit: assert property (failsafeExitClear && devState == FDM_FAILSAFE |->
      ##[1:2] devState == FDM_NORMAL)
      else $error("fail-safe not left");
   cover property (devState == FDM_FAILSAFE);
   cover property ($rose(flags[F_SUPUV]));
   cover property ($fell(errOe));
endmodule : fdm_link_monitor

// [testbench/testbench.sv]
/*
 Self-checking bench: device and host ends joined by one link.
 Assumes both ends share core_clk and the error wire has a pull-up.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import fdm_pkg::*;
   localparam int PCYC = 5;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic batLockout = 1'b0, regLockout = 1'b0, supUvFalling = 1'b0, supUvRising = 1'b0;
   logic wdOverflow = 1'b0, crcValid = 1'b0, allOff = 1'b0, single_led_short_enable = 1'b1;
   logic [2:0] req = 3'h0;
   logic [VOLT_W-1:0] supplyVolts = 6'h14;
   logic [CRC_W-1:0] crcC = 8'h5A, crcS = 8'hA5;
   logic [TH_W-1:0] lowTh = 5'h06;
   logic [NCH-1:0] chEn = '1, diagEn = '1, openDet = '0, shortDet = '0, slsDet = '0;
   logic [NCH-1:0] chOn;
   logic [FLAG_W-1:0] flagsSeen;
   logic errLow, inFailsafe;
   int failures = 0;
   int cmp_count = 0;
   fdm_if link();
   // Pulled-up error wire
   assign link.errIn = !link.errOe;
   always #50 core_clk = !core_clk;
   fdm_device #(.NCH(NCH), .PULSE_CYC(PCYC)) u_fdm_device (.core_clk(core_clk), .rst_n(rst_n),
      .link(link.device), .batLockout(batLockout), .regLockout(regLockout),
      .supplyVolts(supplyVolts), .supUvFalling(supUvFalling), .supUvRising(supUvRising),
      .wdOverflow(wdOverflow), .nvmCrcComputed(crcC), .nvmCrcStored(crcS), .crcValid(crcValid),
      .allChannelsOffOnFault(allOff), .lowSupplyThreshold(lowTh), .singleLedShortEnable(single_led_short_enable),
      .channelEnable(chEn), .channelDiagEnable(diagEn), .openDet(openDet), .shortDet(shortDet),
      .singleShortDet(slsDet), .channelOn_q(chOn));
   fdm_host u_fdm_host (.core_clk(core_clk), .rst_n(rst_n), .link(link.host),
      .reqPorClear(req[0]), .reqFaultClear(req[1]), .reqFsClear(req[2]),
      .flagsSeen_q(flagsSeen), .errLow_q(errLow), .inFailsafe_q(inFailsafe));
   fdm_link_monitor #(.PULSE_CYC(PCYC)) u_fdm_link_monitor (.core_clk(core_clk), .rst_n(rst_n),
      .powerOnFlagClear(link.powerOnFlagClear), .failsafeExitClear(link.failsafeExitClear),
      .flags(link.flags), .devState(link.devState), .errOe(link.errOe));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   // Host clear request: 0 power-on, 1 fault, 2 fail-safe
   task automatic clr(input int i);
      req[i] <= 1'b1;
      cyc(1);
      req[i] <= 1'b0;
      cyc(7);
   endtask : clr
   task automatic t_power_on();
      chk(link.devState, FDM_NORMAL);
      chk(flagsSeen & 6'h03, 6'h03);
      clr(0);
      chk(link.flags & 6'h03, 6'h00);
   endtask : t_power_on
   task automatic t_lowsup();
      supplyVolts <= 6'h0A;
      cyc(8);
      chk(link.flags[F_LOWSUP], 1'b0);
      {supplyVolts, openDet[0], slsDet[1]} <= {6'h09, 2'b11};
      cyc(8);
      chk(link.flags & 6'h06, 6'h06);
      chk(link.channelOpenFlag | link.channelSingleShortFlag, 24'h0);
      clr(1);
      chk(link.flags[F_LOWSUP], 1'b1);
      supplyVolts <= 6'h14;
      cyc(8);
      chk(link.channelOpenFlag | link.channelSingleShortFlag, 24'h3);
      chk(link.flags[F_LOWSUP], 1'b1);
      {openDet[0], slsDet[1]} <= 2'b00;
      cyc(2);
      clr(1);
      chk(link.flags & 6'h06, 6'h00);
   endtask : t_lowsup
   task automatic t_uv();
      {supUvFalling, supUvRising} <= 2'b11;
      cyc(8);
      chk({link.errIn, chOn}, 25'h0);
      chk(errLow, 1'b1);
      chk(link.flags & 6'h0A, 6'h0A);
      supUvFalling <= 1'b0;
      cyc(8);
      chk({link.errIn, chOn}, 25'h0);
      supUvRising <= 1'b0;
      cyc(8);
      chk({link.errIn, chOn}, {1'b1, 24'hFFFFFF});
      chk(errLow, 1'b0);
      chk(link.flags[F_SUPUV], 1'b1);
      clr(1);
      chk(link.flags & 6'h0A, 6'h00);
   endtask : t_uv
   task automatic t_crc();
      int n;
      crcValid <= 1'b1;
      cyc(1);
      crcValid <= 1'b0;
      n = 0;
      while (link.errIn === 1'b1 && n < 10) begin
         cyc(1);
         n++;
      end
      n = 0;
      while (link.errIn === 1'b0 && n < 50) begin
         cyc(1);
         n++;
      end
      chk(n, PCYC);
      chk(link.flags & 6'h12, 6'h12);
      clr(1);
      chk(link.flags & 6'h12, 6'h00);
   endtask : t_crc
   task automatic t_failsafe();
      wdOverflow <= 1'b1;
      cyc(2);
      wdOverflow <= 1'b0;
      cyc(8);
      chk({link.devState, inFailsafe, link.errIn}, {FDM_FAILSAFE, 2'b11});
      chk(link.flags[F_FS], 1'b1);
      shortDet <= 24'h000008;
      cyc(8);
      chk(link.channelShortFlag, 24'h000008);
      chk(flagsSeen[F_ERR], 1'b1);
      chk(chOn, 24'hFFFFF7);
      allOff <= 1'b1;
      cyc(8);
      chk(chOn, 24'h0);
      {allOff, shortDet} <= '0;
      cyc(4);
      clr(1);
      clr(2);
      chk({link.devState, link.flags[F_FS]}, {FDM_NORMAL, 1'b0});
   endtask : t_failsafe
   task automatic t_lockout();
      for (int i = 0; i < 2; i++) begin
         {batLockout, regLockout} <= (i == 0) ? 2'b10 : 2'b01;
         cyc(6);
         chk(link.devState, FDM_POR);
         {batLockout, regLockout} <= 2'b00;
         cyc(8);
         chk({link.devState, link.flags[1:0]}, {FDM_NORMAL, 2'b11});
         clr(0);
      end
   endtask : t_lockout
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   // Main sequence
   initial begin
      cyc(5);
      rst_n <= 1'b1;
      cyc(6);
      t_power_on();
      t_lowsup();
      t_uv();
      t_crc();
      t_failsafe();
      t_lockout();
      close_out();
   end
   // Hang guard
   initial begin
      #200000;
      failures++;
      close_out();
   end
endmodule : testbench

// [verilog/fdm_device.sv]
/*
 Device end: fault flags, error pin driver, state control and output
 gating for the LED driver fault supervision.
 Assumes analog comparator and rail inputs are asynchronous and are
 synchronised here; host strobes arrive on the same clock.
*/
//Function
// [RULE1] Detection continues unchanged in fail-safe
// [RULE2] One-fails-all-fail option shuts every channel; code applies it in fail-safe only
// [RULE3] Flags stay readable in fail-safe
// [RULE4] Rail lockout forces POR, then INIT
// [RULE5] Power-on clear resets POR and global flags
// [RULE6] Supply below threshold sets low-supply flag
// [RULE7] Low-supply flag latched until fault clear
// [RULE8] Low supply suppresses open and single-short
// [RULE9] Threshold field selects 4 to 35 V
// [RULE10] Undervoltage drives error pin low constantly
// [RULE11] Undervoltage disables outputs until rising threshold
// [RULE12] Undervoltage flag latched; pin released on recovery
// [RULE13] CRC mismatch sets flag, pulses pin 50us
// [RULE14] Watchdog overflow enters fail-safe, sets flag
// [RULE15] Clear ignored while cause persists
module fdm_device #(
   parameter int NCH = fdm_pkg::NCH, // Channel count
   parameter int PULSE_CYC = fdm_pkg::ERR_PULSE_CYC // Error pulse length
) (
   input wire logic core_clk, // 10 MHz clock
   input wire logic rst_n, // Async reset, active low
   fdm_if.device link, // Host link
   input wire logic batLockout, // Battery below lockout
   input wire logic regLockout, // Regulator rail below lockout
   input wire logic [fdm_pkg::VOLT_W-1:0] supplyVolts, // Supply in whole volts
   input wire logic supUvFalling, // Supply below falling UV threshold
   input wire logic supUvRising, // Supply below rising UV threshold
   input wire logic wdOverflow, // Comm watchdog timer overflow
   input wire logic [fdm_pkg::CRC_W-1:0] nvmCrcComputed, // Computed CRC
   input wire logic [fdm_pkg::CRC_W-1:0] nvmCrcStored, // Stored CRC
   input wire logic crcValid, // CRC result ready
   input wire logic allChannelsOffOnFault, // One-fails-all-fail option
   input wire logic [fdm_pkg::TH_W-1:0] lowSupplyThreshold, // Low-supply field
   input wire logic singleLedShortEnable, // Single short detect enable
   input wire logic [NCH-1:0] channelEnable, // Channel enables
   input wire logic [NCH-1:0] channelDiagEnable, // Channel diag enables
   input wire logic [NCH-1:0] openDet, // Raw open comparator
   input wire logic [NCH-1:0] shortDet, // Raw short comparator
   input wire logic [NCH-1:0] singleShortDet, // Raw single short comparator
   output logic [NCH-1:0] channelOn_q // Channel drive enable
);
   import fdm_pkg::*;
   localparam int SYN_W = 4 + VOLT_W + 3 * NCH;
   // Supply stage resets to full scale so no false low-supply follows reset
   localparam logic [SYN_W-1:0] SYN_RST = SYN_W'({{VOLT_W{1'b1}}, {(3 * NCH){1'b0}}});
   logic [SYN_W-1:0] syn1_q, syn2_q;
   logic lockS, uvFallS, uvRiseS, wdS;
   logic [VOLT_W-1:0] supS;
   logic [NCH-1:0] openS, shortS, slsS;
   fdm_state_t state_q;
   logic [FLAG_W-1:0] flags_q;
   logic [NCH-1:0] openF_q, shortF_q, slsF_q;
   logic uvActive_q;
   logic [PULSE_W-1:0] pulseCnt_q;
   logic crcBad_q, lowSup, diagOn, crcBad, ledEvt;
   logic [VOLT_W-1:0] thVolts;
   logic [NCH-1:0] openEvt, shortEvt, slsEvt, faultyCh;
   // Two-stage synchroniser for all asynchronous inputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         syn1_q <= SYN_RST;
         syn2_q <= SYN_RST;
      end else begin
         syn1_q <= {batLockout | regLockout, supUvFalling, supUvRising, wdOverflow,
            supplyVolts, openDet, shortDet, singleShortDet};
         syn2_q <= syn1_q;
      end
   end
   assign {lockS, uvFallS, uvRiseS, wdS, supS, openS, shortS, slsS} = syn2_q;
   // [RULE9] Field to volts, capped at top
   assign thVolts = (lowSupplyThreshold > TH_W'(LOWSUP_MAX_V - LOWSUP_MIN_V)) ?
      VOLT_W'(LOWSUP_MAX_V) :
      VOLT_W'(LOWSUP_MIN_V) + VOLT_W'(lowSupplyThreshold) * VOLT_W'(LOWSUP_STEP_V);
   // [RULE6] Continuous low-supply compare
   assign lowSup = supS < thVolts;
   // [RULE8] Open and single-short detection gated by low supply
   assign diagOn = ~lowSup;
   assign crcBad = crcValid & (nvmCrcComputed != nvmCrcStored);
   // [RULE1] Same detection in any running state
   assign openEvt = openS & channelEnable & channelDiagEnable & {NCH{diagOn}};
   assign shortEvt = shortS & channelEnable & channelDiagEnable;
   assign slsEvt = slsS & channelEnable & channelDiagEnable &
      {NCH{diagOn & singleLedShortEnable}};
   assign ledEvt = |(openEvt | shortEvt | slsEvt);
   // [RULE4] State control
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= FDM_POR;
      end else if (lockS) begin
         state_q <= FDM_POR;
      end else begin
         unique case (state_q)
            FDM_POR: state_q <= FDM_INIT;
            FDM_INIT: state_q <= FDM_NORMAL;
            // [RULE14] Watchdog overflow to fail-safe
            FDM_NORMAL: if (wdS) state_q <= FDM_FAILSAFE;
            FDM_FAILSAFE: if (link.failsafeExitClear) state_q <= FDM_NORMAL;
         endcase
      end
   end
   // [RULE11] Undervoltage hysteresis tracker
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         uvActive_q <= 1'b0;
      end else if (uvFallS) begin
         uvActive_q <= 1'b1;
      end else if (!uvRiseS) begin
         uvActive_q <= 1'b0;
      end
   end
   // Global flags; [RULE15] set wins over clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= '0;
      end else if (state_q == FDM_POR) begin
         // [RULE4] POR and global flag on recovery
         flags_q <= '0;
         flags_q[F_POR] <= 1'b1;
         flags_q[F_ERR] <= 1'b1;
      end else begin
         // [RULE5] Power-on clear
         if (link.powerOnFlagClear) begin
            flags_q[F_POR] <= 1'b0;
         end
         // [RULE7] Fault clear for latched faults
         if (link.faultFlagsClear) begin
            flags_q[F_LOWSUP] <= lowSup;
            flags_q[F_SUPUV] <= uvActive_q | uvFallS;
            flags_q[F_CRC] <= crcBad;
         end else begin
            flags_q[F_LOWSUP] <= flags_q[F_LOWSUP] | lowSup;
            flags_q[F_SUPUV] <= flags_q[F_SUPUV] | uvFallS;
            flags_q[F_CRC] <= flags_q[F_CRC] | crcBad;
         end
         // [RULE14] Fail-safe flag
         if (state_q == FDM_NORMAL && wdS) begin
            flags_q[F_FS] <= 1'b1;
         end else if (link.failsafeExitClear) begin
            flags_q[F_FS] <= 1'b0;
         end
         // [RULE10] Global flag from low-supply, UV, CRC or LED fault
         if (lowSup | uvFallS | crcBad | ledEvt) begin
            flags_q[F_ERR] <= 1'b1;
         end else if (link.faultFlagsClear | link.powerOnFlagClear) begin
            flags_q[F_ERR] <= (flags_q[F_POR] & ~link.powerOnFlagClear) |
               ((flags_q[F_LOWSUP] | flags_q[F_SUPUV] | flags_q[F_CRC] |
               (|(openF_q | shortF_q | slsF_q))) & ~link.faultFlagsClear) | uvActive_q;
         end
      end
   end
   // Per-channel LED flags, set wins over clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         openF_q <= '0;
         shortF_q <= '0;
         slsF_q <= '0;
      end else if (link.faultFlagsClear) begin
         openF_q <= openEvt;
         shortF_q <= shortEvt;
         slsF_q <= slsEvt;
      end else begin
         openF_q <= openF_q | openEvt;
         shortF_q <= shortF_q | shortEvt;
         slsF_q <= slsF_q | slsEvt;
      end
   end
   // [RULE13] 50us error pulse on new CRC or LED fault
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         crcBad_q <= 1'b0;
         pulseCnt_q <= '0;
      end else begin
         crcBad_q <= crcBad;
         if ((crcBad & ~crcBad_q) | (|(openEvt & ~openF_q)) | (|(shortEvt & ~shortF_q)) |
            (|(slsEvt & ~slsF_q))) begin
            pulseCnt_q <= PULSE_W'(PULSE_CYC);
         end else if (pulseCnt_q != '0) begin
            pulseCnt_q <= pulseCnt_q - PULSE_W'(1);
         end
      end
   end
   // Channel fault map for fail-safe shutdown
   assign faultyCh = openEvt | shortEvt | slsEvt;
   // [RULE2] Output gating in fail-safe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         channelOn_q <= '0;
      end else if (state_q == FDM_POR || state_q == FDM_INIT || uvActive_q || uvFallS) begin
         channelOn_q <= '0;
      end else if (state_q == FDM_FAILSAFE) begin
         channelOn_q <= (allChannelsOffOnFault && (|faultyCh)) ? '0 :
            (channelEnable & ~faultyCh);
      end else begin
         channelOn_q <= channelEnable;
      end
   end
   // [RULE12] Pin released when UV recovers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link.errOe <= 1'b1;
      end else begin
         link.errOe <= (state_q == FDM_POR) | uvActive_q | uvFallS | (pulseCnt_q != '0);
      end
   end
   // [RULE3] Flags always presented
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link.flags <= '0;
         link.channelOpenFlag <= '0;
         link.channelShortFlag <= '0;
         link.channelSingleShortFlag <= '0;
         link.devState <= 2'(FDM_POR);
      end else begin
         link.flags <= flags_q;
         link.channelOpenFlag <= openF_q;
         link.channelShortFlag <= shortF_q;
         link.channelSingleShortFlag <= slsF_q;
         link.devState <= 2'(state_q);
      end
   end
endmodule : fdm_device

// [verilog/fdm_host.sv]
/*
 Host end: turns user clear requests into one-cycle command strobes and
 presents the device flags and a synchronised error pin level.
 Assumes the device end sits on the same clock.
*/
module fdm_host (
   input wire logic core_clk, // 10 MHz clock
   input wire logic rst_n, // Async reset, active low
   fdm_if.host link, // Device link
   input wire logic reqPorClear, // Request power-on clear
   input wire logic reqFaultClear, // Request fault clear
   input wire logic reqFsClear, // Request fail-safe exit
   output logic [fdm_pkg::FLAG_W-1:0] flagsSeen_q, // Captured flags
   output logic errLow_q, // Error pin seen low
   output logic inFailsafe_q // Device in fail-safe
);
   import fdm_pkg::*;
   logic porStb_q, faultStb_q, fsStb_q;
   logic errMeta_q;
   // [RULE5] Self-clearing strobes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         porStb_q <= 1'b0;
         faultStb_q <= 1'b0;
         fsStb_q <= 1'b0;
      end else begin
         porStb_q <= reqPorClear & ~porStb_q;
         faultStb_q <= reqFaultClear & ~faultStb_q;
         fsStb_q <= reqFsClear & ~fsStb_q;
      end
   end
   assign link.powerOnFlagClear = porStb_q;
   assign link.faultFlagsClear = faultStb_q;
   assign link.failsafeExitClear = fsStb_q;
   // Flag readback and pin synchroniser
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flagsSeen_q <= '0;
         errMeta_q <= 1'b1;
         errLow_q <= 1'b0;
         inFailsafe_q <= 1'b0;
      end else begin
         flagsSeen_q <= link.flags;
         errMeta_q <= ~link.errOe;
         errLow_q <= ~errMeta_q;
         inFailsafe_q <= (link.devState == 2'(FDM_FAILSAFE));
      end
   end
endmodule : fdm_host

// [verilog/fdm_if.sv]
/*
 Link between the fault manager and the host: command strobes, flag
 readback and the open-drain error pin as two signals.
 Assumes the testbench resolves the error wire from errOe.
*/
interface fdm_if;
   logic powerOnFlagClear;
   logic faultFlagsClear;
   logic failsafeExitClear;
   logic [fdm_pkg::FLAG_W-1:0] flags;
   logic [fdm_pkg::NCH-1:0] channelOpenFlag;
   logic [fdm_pkg::NCH-1:0] channelShortFlag;
   logic [fdm_pkg::NCH-1:0] channelSingleShortFlag;
   logic [1:0] devState;
   logic errOe;
   logic errIn;
   modport device (input powerOnFlagClear, faultFlagsClear, failsafeExitClear, errIn,
      output flags, channelOpenFlag, channelShortFlag, channelSingleShortFlag, devState,
      errOe);
   modport host (output powerOnFlagClear, faultFlagsClear, failsafeExitClear,
      input flags, channelOpenFlag, channelShortFlag, channelSingleShortFlag, devState,
      errOe, errIn);
endinterface : fdm_if

// [verilog/fdm_pkg.sv]
/*
 Shared constants for the fault supervision link between the LED driver
 fault manager and its host controller.
 Assumes one 10 MHz clock common to both ends.
*/
package fdm_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int NCH = 24;
   // Error pin pulse length
   localparam int ERR_PULSE_US = 50;
   localparam int ERR_PULSE_CYC = (ERR_PULSE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
      ERR_PULSE_US * (CLK_HZ / 1_000_000);
   localparam int PULSE_W = 10;
   // Low-supply threshold field: 0 means 4 V, step 1 V, up to 35 V
   localparam int LOWSUP_MIN_V = 4;
   localparam int LOWSUP_MAX_V = 35;
   localparam int LOWSUP_STEP_V = 1;
   localparam int TH_W = 5;
   localparam int VOLT_W = 6;
   localparam logic [TH_W-1:0] LOWSUP_TH_RST = 5'h00;
   localparam int CRC_W = 8;
   // Flag register bit positions
   localparam int FLAG_W = 6;
   localparam int F_POR = 0;
   localparam int F_ERR = 1;
   localparam int F_LOWSUP = 2;
   localparam int F_SUPUV = 3;
   localparam int F_CRC = 4;
   localparam int F_FS = 5;
   typedef enum logic [1:0] {FDM_POR, FDM_INIT, FDM_NORMAL, FDM_FAILSAFE} fdm_state_t;
endpackage : fdm_pkg
